// file: src/pad_block.sv
// Purpose: block of registered bidirectional pad cells with apb setup
// Assumes: core lines, edge clocks and apb share pclk; pad inputs do not
// Notes: cell clocks are levels, a register fires on their rising edge
//
// Local design decisions: register access over APB and the placing of the registers.

`timescale 1ns/100ps
`default_nettype none

// What this block does
// - combinational and registered inputs, each delayed
// - row block holds four cells, 32 lines
// - column block holds five cells, 40 lines
// - row feeds all routing, column only column
// - six edge clock lines 5..0 per region
// - each cell selects all its control sources
// - capture register has own clock and enable
// - launch and drive registers share clock, enable
// - shared clears, each register may ignore them
// - input, output or bidir with drive register
// - reject drive strength with series termination
// - one capture, two launch, two drive registers
module pad_block
   import pad_pkg::*;
(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [ADDR_W-1:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic [CORE_LINES-1:0] core_lines,
   input wire logic [ROWCOL_CTL-1:0] rowcol_ctl,
   input wire logic [EDGE_CLKS-1:0] edge_clk,
   input wire logic [NCELL-1:0] pad_in,
   output logic [NCELL-1:0] pad_out,
   output logic [NCELL-1:0] pad_oe_n,
   output logic [2*NCELL-1:0] row_feed,
   output logic [2*NCELL-1:0] col_feed,
   output logic [2*NCELL-1:0] direct_feed
);

   // software-visible state
   logic col_mode_r;
   logic reject_r;
   logic [31:0] prdata_r;
   cell_cfg_s cfg_r [NCELL];
   cell_mode_s mode_r [NCELL];

   // bus decode
   logic setup;
   logic access;
   logic wr;
   logic cell_hit;
   logic mode_hit;
   logic [2:0] cell_idx;
   logic mapped;
   logic bad_mode;
   cell_mode_s wmode;
   logic [31:0] rd_word;

   // per-cell state gathered for status and feeds
   logic [NCELL-1:0] cap_v;
   logic [NCELL-1:0] pin_v;
   logic [NCELL-1:0] drv_v;
   logic [2*NCELL-1:0] feed_v;

   // index of the cell whose words an address falls into
   function automatic logic [2:0] cell_of(input logic [11:0] a);
      logic [11:0] off;
      off = a - CELL_BASE;
      return off[CELL_STRIDE_LOG2 +: 3];
   endfunction : cell_of

   // true when an address lies in the cell word range
   function automatic logic in_cells(input logic [11:0] a);
      return (a >= CELL_BASE) && (a < CELL_END) && (a[1:0] == 2'h0);
   endfunction : in_cells

   // apb phase decode; no wait states
   assign setup = psel & ~penable;
   assign access = psel & penable;
   assign wr = access & pwrite;
   assign cell_hit = in_cells(paddr);
   assign mode_hit = cell_hit & paddr[CELL_MODE_BIT];
   assign cell_idx = cell_of(paddr);
   assign mapped = (paddr == CTRL_OFF) || (paddr == STATUS_OFF) || cell_hit;
   assign wmode = cell_mode_s'(pwdata);
   assign bad_mode = pwrite & mode_hit & wmode.drv_str & wmode.ser_term;

   // refused writes and holes in the map both answer with an error
   assign pready = 1'b1;
   assign pslverr = access & (~mapped | bad_mode);

   // block kind: row block or column block
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         col_mode_r <= CTRL_COL_RST;
      end else if (wr && paddr == CTRL_OFF) begin
         col_mode_r <= pwdata[CTRL_COL_BIT];
      end
   end

   // cell selection and mode words; a conflicting mode word is dropped
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         for (int c = 0; c < NCELL; c++) begin
            cfg_r[c] <= cell_cfg_s'(CFG_RST);
            mode_r[c] <= cell_mode_s'(MODE_RST);
         end
      end else if (wr && cell_hit) begin
         if (!paddr[CELL_MODE_BIT]) begin
            cfg_r[cell_idx] <= cell_cfg_s'(pwdata);
         end else if (!bad_mode) begin
            mode_r[cell_idx] <= wmode;
         end
      end
   end

   // sticky reject flag, write one to clear; a new reject wins the clear
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         reject_r <= 1'b0;
      end else if (wr && bad_mode) begin
         reject_r <= 1'b1;
      end else if (wr && paddr == STATUS_OFF && pwdata[STAT_REJ_BIT]) begin
         reject_r <= 1'b0;
      end
   end

   // read mux
   always_comb begin
      rd_word = '0;
      if (paddr == CTRL_OFF) begin
         rd_word[CTRL_COL_BIT] = col_mode_r;
      end else if (paddr == STATUS_OFF) begin
         rd_word[STAT_CAP_LSB +: NCELL] = cap_v;
         rd_word[STAT_PIN_LSB +: NCELL] = pin_v;
         rd_word[STAT_DRV_LSB +: NCELL] = drv_v;
         rd_word[STAT_REJ_BIT] = reject_r;
      end else if (cell_hit && cell_idx < 3'(NCELL)) begin
         rd_word = paddr[CELL_MODE_BIT] ? 32'(mode_r[cell_idx])
                                        : 32'(cfg_r[cell_idx]);
      end
   end

   // read data is caught in the setup cycle so it leaves a flop
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata_r <= '0;
      end else if (setup && !pwrite) begin
         prdata_r <= rd_word;
      end
   end

   assign prdata = prdata_r;

   // one slice per pad cell
   for (genvar i = 0; i < NCELL; i++) begin : gen_cell
      logic [LINES_PER_CELL-1:0] lines;
      logic [NSRC-1:0] src;
      logic active;
      logic pin_s1;
      logic pin_s2;
      logic in_lvl;
      logic in_prev;
      logic out_lvl;
      logic out_prev;
      logic in_tick;
      logic out_tick;
      logic ce_in;
      logic ce_out;
      logic aclr;
      logic sclr;
      logic oe_src;
      logic oe_lvl;
      logic drive_r;
      logic pad_out_r;
      logic comb_q;
      logic reg_q;
      logic [NREG-1:0] d_v;
      logic [NREG-1:0] load_v;
      logic [NREG-1:0] q;

      // the fifth cell only exists in a column block
      assign active = (i < ROW_CELLS) || col_mode_r;
      assign lines = core_lines[i*LINES_PER_CELL +: LINES_PER_CELL];

      // sources: edge clocks 5..0, row/column lines, local cell lines
      assign src = {edge_clk, rowcol_ctl, lines};

      // every control of the cell picks its own source
      assign in_lvl = sel_src(src, cfg_r[i].clk_in_sel);
      assign ce_in = sel_src(src, cfg_r[i].ce_in_sel);
      assign out_lvl = sel_src(src, cfg_r[i].clk_out_sel);
      assign ce_out = sel_src(src, cfg_r[i].ce_out_sel);
      assign aclr = sel_src(src, cfg_r[i].aclr_sel);
      assign sclr = sel_src(src, cfg_r[i].sclr_sel);
      assign oe_src = sel_src(src, cfg_r[i].oe_sel);

      // pad level is foreign to pclk; first flop feeds only the second
      always_ff @(posedge pclk or negedge presetn) begin
         if (!presetn) begin
            pin_s1 <= 1'b0;
            pin_s2 <= 1'b0;
         end else begin
            pin_s1 <= pad_in[i];
            pin_s2 <= pin_s1;
         end
      end

      // rising edges of the selected cell clocks
      always_ff @(posedge pclk or negedge presetn) begin
         if (!presetn) begin
            in_prev <= 1'b0;
            out_prev <= 1'b0;
         end else begin
            in_prev <= in_lvl;
            out_prev <= out_lvl;
         end
      end

      assign in_tick = in_lvl & ~in_prev;
      assign out_tick = out_lvl & ~out_prev;

      // capture runs on its own clock; launch and drive share theirs
      assign d_v[REG_CAP] = pin_s2;
      assign d_v[REG_LA] = lines[LINE_DA];
      assign d_v[REG_LB] = lines[LINE_DB];
      assign d_v[REG_OA] = oe_src;
      assign d_v[REG_OB] = lines[LINE_OB];
      assign load_v[REG_CAP] = active & in_tick & ce_in;
      assign load_v[REG_LA] = active & out_tick & ce_out;
      assign load_v[REG_LB] = active & out_tick & ce_out;
      assign load_v[REG_OA] = active & out_tick & ce_out;
      assign load_v[REG_OB] = active & out_tick & ce_out;

      // five registers on one shared pair of clears
      for (genvar r = 0; r < NREG; r++) begin : gen_reg
         pad_reg u_reg (
            .pclk(pclk),
            .presetn(presetn),
            .d(d_v[r]),
            .load(load_v[r]),
            .sclr(sclr),
            .aclr(aclr),
            .ign_sclr(mode_r[i].ign_sclr[r]),
            .ign_aclr(mode_r[i].ign_aclr[r]),
            .preset(mode_r[i].preset[r]),
            .q(q[r])
         );
      end

      // in ddr the launch clock level picks which register drives
      assign oe_lvl = (mode_r[i].ddr_oe && !out_lvl) ? q[REG_OB]
                                                      : q[REG_OA];

      always_ff @(posedge pclk or negedge presetn) begin
         if (!presetn) begin
            pad_out_r <= 1'b0;
         end else if (mode_r[i].ddr_out && !out_lvl) begin
            pad_out_r <= q[REG_LB];
         end else begin
            pad_out_r <= q[REG_LA];
         end
      end

      // output buffer enable follows the direction of use
      always_ff @(posedge pclk or negedge presetn) begin
         if (!presetn) begin
            drive_r <= 1'b0;
         end else if (!active) begin
            drive_r <= 1'b0;
         end else begin
            unique case (mode_r[i].mode)
               DIR_INPUT: drive_r <= 1'b0;
               DIR_OUTPUT: drive_r <= 1'b1;
               DIR_BIDIR: drive_r <= oe_lvl;
               DIR_UNUSED: drive_r <= 1'b0;
            endcase
         end
      end

      // two input paths, each with its own delay chain
      pad_delay u_dly_comb (
         .pclk(pclk),
         .presetn(presetn),
         .d(pin_s2),
         .sel(mode_r[i].dly_comb),
         .q(comb_q)
      );

      pad_delay u_dly_reg (
         .pclk(pclk),
         .presetn(presetn),
         .d(q[REG_CAP]),
         .sel(mode_r[i].dly_reg),
         .q(reg_q)
      );

      assign feed_v[2*i] = active & comb_q;
      assign feed_v[2*i+1] = active & reg_q;
      assign pad_out[i] = pad_out_r;
      assign pad_oe_n[i] = ~drive_r;
      assign cap_v[i] = q[REG_CAP];
      assign pin_v[i] = pin_s2;
      assign drv_v[i] = drive_r;
   end

   // a column block reaches only column routing
   assign col_feed = feed_v;
   assign row_feed = col_mode_r ? '0 : feed_v;
   assign direct_feed = col_mode_r ? '0 : feed_v;

   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   AST_REJECT_KEEPS: assert property (
      (wr && bad_mode && cell_idx == 3'h0)
      |-> pslverr ##1 (mode_r[0] == $past(mode_r[0])) && reject_r)
      else $error("conflicting drive setup was not refused");
   AST_UNMAPPED_ERR: assert property (
      (access && !mapped) |-> pslverr && pready)
      else $error("unmapped access did not answer an error");
   AST_ROW_FIFTH_OFF: assert property (
      (!col_mode_r && $past(!col_mode_r)) |-> pad_oe_n[4] && !feed_v[9])
      else $error("fifth cell active in a row block");
   AST_COL_ONLY: assert property (
      col_mode_r |-> (row_feed == '0) && (direct_feed == '0))
      else $error("column block drove row or direct routing");
   AST_OUTPUT_DRIVES: assert property (
      (mode_r[0].mode == DIR_OUTPUT) ##1 (mode_r[0].mode == DIR_OUTPUT)
      |-> !pad_oe_n[0])
      else $error("output cell not driving its pin");
   AST_INPUT_FLOATS: assert property (
      (mode_r[0].mode == DIR_INPUT) |=> pad_oe_n[0])
      else $error("input cell drives its pin");
   AST_CAPTURE_LOAD: assert property (
      (gen_cell[0].load_v[REG_CAP] && !gen_cell[0].aclr
       && !gen_cell[0].sclr)
      |=> gen_cell[0].q[REG_CAP] == $past(gen_cell[0].pin_s2))
      else $error("capture register missed its pin value");
   AST_LAUNCH_SHARED: assert property (
      (gen_cell[1].out_tick && gen_cell[1].ce_out && !gen_cell[1].aclr
       && !gen_cell[1].sclr)
      |=> gen_cell[1].q[REG_LA] == $past(core_lines[8])
          && gen_cell[1].q[REG_OA] == $past(gen_cell[1].oe_src))
      else $error("launch and drive registers did not load together");
   AST_DDR_LOW_PHASE: assert property (
      (mode_r[2].ddr_out && !gen_cell[2].out_lvl)
      |=> pad_out[2] == $past(gen_cell[2].q[REG_LB]))
      else $error("ddr low phase shows wrong launch register");

   COV_DDR_OUT: cover property (
      mode_r[2].ddr_out && gen_cell[2].out_tick);
   COV_REJECT: cover property (wr && bad_mode);
   COV_COLUMN: cover property (col_mode_r && !pad_oe_n[4]);
   COV_BIDIR_TURN: cover property (
      (mode_r[2].mode == DIR_BIDIR) && $fell(pad_oe_n[2]));

endmodule : pad_block

`default_nettype wire

// file: src/pad_pkg.sv
// Purpose: shared constants, layouts and helpers for the pad cell block
// Assumes: apb register map with 32-bit words, one clock pclk
// Notes: clocks and clears of the cells are level signals on pclk

package pad_pkg;

   // geometry of a block
   localparam int NCELL = 5;
   localparam int ROW_CELLS = 4;
   localparam int LINES_PER_CELL = 8;
   localparam int CORE_LINES = 40;
   localparam int EDGE_CLKS = 6;
   localparam int ROWCOL_CTL = 2;
   localparam int NSRC = 16;
   localparam int SEL_W = 4;
   localparam int DLY_W = 2;
   localparam int DLY_MAX = 3;

   // register roles inside one cell
   localparam int NREG = 5;
   localparam int REG_CAP = 0;
   localparam int REG_LA = 1;
   localparam int REG_LB = 2;
   localparam int REG_OA = 3;
   localparam int REG_OB = 4;

   // positions of the dedicated data lines inside a cell bundle
   localparam int LINE_DA = 0;
   localparam int LINE_DB = 1;
   localparam int LINE_OB = 3;

   // register map, byte addresses
   localparam int ADDR_W = 12;
   localparam logic [11:0] CTRL_OFF = 12'h000;
   localparam logic [11:0] STATUS_OFF = 12'h004;
   localparam logic [11:0] CELL_BASE = 12'h010;
   localparam logic [11:0] CELL_END = 12'h038;
   localparam int CELL_STRIDE_LOG2 = 3;
   localparam int CELL_MODE_BIT = 2;

   // field positions and reset values
   localparam int CTRL_COL_BIT = 0;
   localparam int STAT_CAP_LSB = 0;
   localparam int STAT_PIN_LSB = 5;
   localparam int STAT_DRV_LSB = 10;
   localparam int STAT_REJ_BIT = 15;
   localparam logic CTRL_COL_RST = 1'b0;
   localparam logic [31:0] CFG_RST = 32'h0000_0000;
   localparam logic [31:0] MODE_RST = 32'h0000_0000;

   typedef enum logic [1:0] {
      DIR_INPUT, DIR_OUTPUT, DIR_BIDIR, DIR_UNUSED
   } dir_e;

   // per-cell source selection word
   typedef struct packed {
      logic [3:0] spare;
      logic [3:0] oe_sel;
      logic [3:0] sclr_sel;
      logic [3:0] aclr_sel;
      logic [3:0] ce_out_sel;
      logic [3:0] clk_out_sel;
      logic [3:0] ce_in_sel;
      logic [3:0] clk_in_sel;
   } cell_cfg_s;

   // per-cell mode word
   typedef struct packed {
      logic [6:0] spare;
      logic [1:0] dly_reg;
      logic [1:0] dly_comb;
      logic ser_term;
      logic drv_str;
      logic [4:0] ign_sclr;
      logic [4:0] ign_aclr;
      logic [4:0] preset;
      logic ddr_oe;
      logic ddr_out;
      dir_e mode;
   } cell_mode_s;

   // pick one of the sixteen control sources of a cell
   function automatic logic sel_src(input logic [15:0] v,
                                    input logic [3:0] s);
      return v[s];
   endfunction : sel_src

endpackage : pad_pkg

// file: src/pad_reg.sv
// Purpose: one cell register with shared clears and per-register options
// Assumes: clears and load are levels on pclk
// Notes: the async clear acts on the output at once, the flop follows

`timescale 1ns/100ps
`default_nettype none

module pad_reg
   import pad_pkg::*;
(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic d,
   input wire logic load,
   input wire logic sclr,
   input wire logic aclr,
   input wire logic ign_sclr,
   input wire logic ign_aclr,
   input wire logic preset,
   output logic q
);

   logic q_r;
   logic aclr_on;
   logic sclr_on;

   // each register may ignore either clear
   assign aclr_on = aclr & ~ign_aclr;
   assign sclr_on = sclr & ~ign_sclr;

   // clears load the preset value instead of zero when asked
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         q_r <= 1'b0;
      end else if (aclr_on || sclr_on) begin
         q_r <= preset;
      end else if (load) begin
         q_r <= d;
      end
   end

   // async clear must not wait for an edge
   assign q = aclr_on ? preset : q_r;

   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   AST_SCLR_PRESET: assert property (
      (sclr_on && !aclr_on) |=> q_r == $past(preset))
      else $error("sync clear did not load preset value");
   AST_IGNORE_HOLD: assert property (
      (ign_sclr && ign_aclr && !load) |=> q_r == $past(q_r))
      else $error("ignored clears changed the register");

endmodule : pad_reg

`default_nettype wire

// file: src/pad_delay.sv
// Purpose: programmable delay chain on one input path to the core
// Assumes: delay counted in pclk cycles, 0 to DLY_MAX
// Notes: setting zero passes the input straight through

`timescale 1ns/100ps
`default_nettype none

module pad_delay
   import pad_pkg::*;
(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic d,
   input wire logic [DLY_W-1:0] sel,
   output logic q
);

   logic [DLY_MAX-1:0] sh_r;

   // shift line of the chain
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         sh_r <= '0;
      end else begin
         sh_r <= {sh_r[DLY_MAX-2:0], d};
      end
   end

   // tap chosen by the setting
   assign q = (sel == 2'h0) ? d : sh_r[sel - 2'h1];

   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   AST_DELAY_TWO: assert property (
      (sel == 2'h2) ##2 (sel == 2'h2) |-> q == $past(d, 2))
      else $error("delay chain tap two is wrong");

endmodule : pad_delay

`default_nettype wire

// file: tb/core_model.sv
// Purpose: core side model driving routing lines and edge clocks
// Assumes: every source changes just after a rising pclk edge
// Notes: edge clocks stand low unless a test raises them

`timescale 1ns/100ps
`default_nettype none

module core_model
   import pad_pkg::*;
(
   input wire logic pclk,
   output logic [CORE_LINES-1:0] core_lines,
   output logic [ROWCOL_CTL-1:0] rowcol_ctl,
   output logic [EDGE_CLKS-1:0] edge_clk
);
   // all low at start so no stray clock edge reaches a cell
   initial begin
      core_lines = '0;
      rowcol_ctl = '0;
      edge_clk = '0;
   end

   // source s of cell c: 0..7 lines, 8..9 row/col, 10..15 edge
   task automatic put(input int c, input int s, input logic v);
      @(posedge pclk);
      if (s < 8) core_lines[8*c+s] <= v;
      else if (s < 10) rowcol_ctl[s-8] <= v;
      else edge_clk[s-10] <= v;
   endtask : put

   // one short pulse on source s of cell c, then it rests low again
   task automatic pulse(input int s, input int c = 0);
      put(c, s, 1'b1);
      put(c, s, 1'b0);
   endtask : pulse
endmodule : core_model

`default_nettype wire

// file: tb/tb_top.sv
// Purpose: self-checking bench for the pad cell block
// Assumes: apb answers by pready, core_model drives the routing
// Notes: pin and line values are random from a fixed seed

`timescale 1ns/100ps
`default_nettype none

module tb_top;
   import pad_pkg::*;
   localparam logic [31:0] CFG = 32'h0467_2a5b;
   logic pclk = 1'b0;
   logic presetn = 1'b0;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [ADDR_W-1:0] paddr = '0;
   logic [31:0] pwdata = '0;
   logic [31:0] prdata, rv;
   logic pready, pslverr, ev, a, b, c;
   logic [NCELL-1:0] pad_in = '0;
   logic [NCELL-1:0] pad_out, pad_oe_n;
   logic [2*NCELL-1:0] row_feed, col_feed, direct_feed;
   logic [CORE_LINES-1:0] core_lines;
   logic [ROWCOL_CTL-1:0] rowcol_ctl;
   logic [EDGE_CLKS-1:0] edge_clk;
   int bad_count = 0;
   int samples_checked = 0;

   // 125 MHz bus clock
   always #4 pclk = ~pclk;

   core_model m (.pclk, .core_lines, .rowcol_ctl, .edge_clk);
   pad_block dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
      .pwdata, .prdata, .pready, .pslverr, .core_lines, .rowcol_ctl,
      .edge_clk, .pad_in, .pad_out, .pad_oe_n, .row_feed, .col_feed,
      .direct_feed);

   task automatic tally_and_finish();
      if (bad_count == 0 && samples_checked > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask : tally_and_finish

   task automatic chk(input logic [31:0] g, input logic [31:0] e);
      samples_checked++;
      if (g !== e) begin
         bad_count++;
         $display("unexpected at %0t: got %h want %h", $time, g, e);
      end
   endtask : chk

   // one transfer; request held until pready is seen at an edge
   task automatic apb(input logic w, input logic [11:0] ad,
         input logic [31:0] d);
      int n;
      n = 0;
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= ad;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      while (pready !== 1'b1 && n < 100) begin
         @(posedge pclk);
         n++;
      end
      if (n == 100) bad_count++;
      rv = prdata;
      ev = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb

   task automatic rd(input logic [11:0] ad, input logic [31:0] x);
      apb(1'b0, ad, '0);
      chk(rv, x);
   endtask : rd

   function automatic logic [11:0] ca(input int i);
      return CELL_BASE + 12'(8 * i);
   endfunction : ca

   // launch data va into cell i on a pulse of source s
   task automatic go(input int i, input logic va, input int s);
      m.put(i, LINE_DA, va);
      m.pulse(s);
      repeat (4) @(posedge pclk);
   endtask : go

   // stops a hung run through the normal closing path
   initial begin
      #400000;
      bad_count++;
      tally_and_finish();
   end

   initial begin
      void'($urandom(19));
      repeat (10) @(posedge pclk);
      presetn <= 1'b1;
      chk(pad_oe_n, 5'h1f);
      rd(CTRL_OFF, 32'h0);
      rd(STATUS_OFF, 32'h0);
      // unmapped words refuse and read zero
      apb(1'b1, 12'h008, 32'hffff_ffff);
      chk(ev, 1'b1);
      rd(12'h03c, 32'h0);
      chk(ev, 1'b1);
      for (int i = 0; i < NCELL; i++) begin
         apb(1'b1, ca(i), CFG);
         m.put(i, 2, 1'b1);
         m.put(i, 5, 1'b1);
      end
      // drive strength with series termination is refused
      apb(1'b1, ca(0) + 12'h004, 32'h0018_0001);
      chk(ev, 1'b1);
      rd(ca(0) + 12'h004, 32'h0);
      rd(STATUS_OFF, 32'h0000_8000);
      apb(1'b1, STATUS_OFF, 32'h0000_8000);
      rd(STATUS_OFF, 32'h0);
      apb(1'b1, ca(0) + 12'h004, 32'h0008_0001);
      chk(ev, 1'b0);
      // every edge clock line can launch cell 1
      apb(1'b1, ca(1) + 12'h004, 32'h1);
      a = 1'($urandom);
      for (int k = 0; k < EDGE_CLKS; k++) begin
         a = ~a;
         apb(1'b1, ca(1), {CFG[31:12], 4'(10 + k), CFG[7:0]});
         go(1, a, 10 + k);
         chk(pad_out[1], a);
      end
      chk(pad_oe_n[1], 1'b0);
      m.put(1, 2, 1'b0);
      go(1, ~a, 15);
      chk(pad_out[1], a);
      // capture runs on its own clock and enable
      apb(1'b1, ca(0) + 12'h004, 32'h0);
      b = 1'($urandom);
      pad_in <= {4'(~b), b};
      repeat (4) @(posedge pclk);
      chk(pad_oe_n[0], 1'b1);
      m.pulse(11);
      repeat (4) @(posedge pclk);
      apb(1'b0, STATUS_OFF, '0);
      chk(rv[0], b);
      chk(col_feed[1:0], {b, b});
      pad_in[0] <= ~b;
      repeat (4) @(posedge pclk);
      m.pulse(10);
      repeat (4) @(posedge pclk);
      apb(1'b0, STATUS_OFF, '0);
      chk(rv[0], b);
      chk(col_feed[1:0], {b, ~b});
      // combinational path with the longest delay, registered path two
      apb(1'b1, ca(0) + 12'h004, 32'h0160_0000);
      pad_in[0] <= b;
      repeat (3) @(posedge pclk);
      chk(col_feed[0], !b);
      repeat (6) @(posedge pclk);
      chk(col_feed[0], b);
      // double rate data and drive enable on cell 2
      apb(1'b1, ca(2) + 12'h004, 32'he);
      a = 1'($urandom);
      c = 1'($urandom);
      m.put(2, LINE_DB, ~a);
      m.put(2, 4, c);
      m.put(2, LINE_OB, ~c);
      m.put(2, LINE_DA, a);
      m.put(0, 10, 1'b1);
      repeat (3) @(posedge pclk);
      chk(pad_out[2], a);
      chk(pad_oe_n[2], !c);
      m.put(0, 10, 1'b0);
      repeat (3) @(posedge pclk);
      chk(pad_out[2], !a);
      chk(pad_oe_n[2], c);
      // clears on cell 3: preset, async, ignore options
      apb(1'b1, ca(3) + 12'h004, 32'h21);
      go(3, 1'b0, 10);
      chk(pad_out[3], 1'b0);
      m.pulse(6, 3);
      repeat (3) @(posedge pclk);
      chk(pad_out[3], 1'b1);
      apb(1'b1, ca(3) + 12'h004, 32'h1);
      m.put(3, 7, 1'b1);
      repeat (3) @(posedge pclk);
      chk(pad_out[3], 1'b0);
      apb(1'b1, ca(3) + 12'h004, 32'h21);
      repeat (3) @(posedge pclk);
      chk(pad_out[3], 1'b1);
      m.put(3, 7, 1'b0);
      apb(1'b1, ca(3) + 12'h004, 32'h8401);
      m.pulse(6, 3);
      repeat (3) @(posedge pclk);
      chk(pad_out[3], 1'b1);
      // row block leaves cell 4 idle, column block uses it
      pad_in[4:1] <= 4'($urandom);
      apb(1'b1, ca(4) + 12'h004, 32'h1);
      go(4, 1'b1, 10);
      chk(pad_oe_n[4], 1'b1);
      chk(col_feed[9:8], 2'b00);
      chk({row_feed[0], direct_feed[0]}, {b, b});
      apb(1'b1, CTRL_OFF, 32'h1);
      rd(CTRL_OFF, 32'h1);
      go(4, 1'b1, 10);
      chk({pad_out[4], pad_oe_n[4]}, 2'b10);
      chk({row_feed, direct_feed}, 20'h0);
      chk(col_feed[0], b);
      tally_and_finish();
   end
endmodule : tb_top

`default_nettype wire
